// ===== rtl/adcu_flag_eval.sv
// Purpose: Derives the six condition flags of an add with carry
// Assumes: Sum and carries come from the nibble adder chain
// Notes:   Combinational; the caller registers the result
`timescale 1ns/100ps
`default_nettype none
module adcu_flag_eval (
    input  wire logic [7:0] opA,
    input  wire logic [7:0] opB,
    input  wire logic [7:0] sum,
    input  wire logic       carryHalf,
    input  wire logic       carryOut,
    output logic      [5:0] flags
);

    always_comb begin
        flags                   = adcu_pkg::FLAGS_RST;
        flags[adcu_pkg::FLG_C]  = carryOut;
        flags[adcu_pkg::FLG_Z]  = (sum == adcu_pkg::ZERO_BYTE);
        flags[adcu_pkg::FLG_S]  = sum[7];
        // Same-signed operands giving a result of the other sign
        flags[adcu_pkg::FLG_V]  = (opA[7] == opB[7]) &&
                                  (sum[7] != opA[7]);
        flags[adcu_pkg::FLG_D]  = 1'b0;
        flags[adcu_pkg::FLG_H]  = carryHalf;
    end

endmodule
`default_nettype wire

// ===== rtl/adcu_nibble_add.sv
// Purpose: Ripple adder slice with carry in and carry out
// Assumes: Purely combinational, width set by parameter
// Notes:   Two slices chained give the half-carry for free
`timescale 1ns/100ps
`default_nettype none
module adcu_nibble_add #(
    parameter int unsigned W = 4
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         cin,
    output logic      [W-1:0] sum,
    output logic              cout
);

    logic [W:0] carry;

    assign carry[0] = cin;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign sum[i]     = a[i] ^ b[i] ^ carry[i];
            assign carry[i+1] = (a[i] & b[i]) | (carry[i] & (a[i] ^ b[i]));
        end
    endgenerate

    assign cout = carry[W];

endmodule
`default_nettype wire

// ===== rtl/adcu_pkg.sv
// Purpose: Shared constants and types of the add-with-carry unit
// Assumes: Eight-bit data path, six condition flags
// Notes:   Flag vector order is fixed here and used by the flag evaluator and the unit
package adcu_pkg;

    localparam int unsigned DATA_W  = 8;
    localparam int unsigned NIB_W   = 4;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned FLAG_W  = 6;

    // Flag positions inside the six-bit flag vector
    localparam int unsigned FLG_C   = 5;
    localparam int unsigned FLG_Z   = 4;
    localparam int unsigned FLG_S   = 3;
    localparam int unsigned FLG_V   = 2;
    localparam int unsigned FLG_D   = 1;
    localparam int unsigned FLG_H   = 0;

    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Cycles from an accepted start to the write-back strobe
    localparam int unsigned EXEC_LAT = 2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_CALC   = 2'b01,
        ST_COMMIT = 2'b10
    } adcu_state_t;

endpackage

// ===== rtl/adcu_unit.sv
// Purpose: Add-with-carry execution unit with its own flag register
// Assumes: Operands come from the register file already fetched
// Notes:   Result and flags leave together; one op per two cycles
`timescale 1ns/100ps
`default_nettype none
module adcu_unit #(
    parameter int unsigned DATA_W = adcu_pkg::DATA_W,
    parameter int unsigned ADDR_W = adcu_pkg::ADDR_W
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              start,
    input  wire logic [DATA_W-1:0] dstVal,
    input  wire logic [DATA_W-1:0] srcVal,
    input  wire logic [ADDR_W-1:0] dstAddr,
    input  wire logic [ADDR_W-1:0] srcAddr,
    input  wire logic              flagLoad,
    input  wire logic [5:0]        flagIn,
    output logic                   ready,
    output logic                   wrEn,
    output logic      [ADDR_W-1:0] wrAddr,
    output logic      [DATA_W-1:0] wrData,
    output logic      [5:0]        flags
);

    localparam int unsigned NIB = adcu_pkg::NIB_W;

    adcu_pkg::adcu_state_t state_q;
    adcu_pkg::adcu_state_t state_d;

    logic [DATA_W-1:0] opA_q;
    logic [DATA_W-1:0] opA_d;
    logic [DATA_W-1:0] opB_q;
    logic [DATA_W-1:0] opB_d;
    logic              cin_q;
    logic              cin_d;
    logic [ADDR_W-1:0] dAddr_q;
    logic [ADDR_W-1:0] dAddr_d;
    logic [ADDR_W-1:0] sAddr_q;
    logic [ADDR_W-1:0] sAddr_d;

    logic              wrEn_q;
    logic              wrEn_d;
    logic [ADDR_W-1:0] wrAddr_q;
    logic [ADDR_W-1:0] wrAddr_d;
    logic [DATA_W-1:0] wrData_q;
    logic [DATA_W-1:0] wrData_d;
    logic [5:0]        flags_q;
    logic [5:0]        flags_d;

    logic [DATA_W-1:0] sum;
    logic [DATA_W/NIB:0] nibCarry;
    logic [5:0]        newFlags;
    logic              accept;

    // A new op may start while the previous one is committing, since
    // the carry it needs is already in the flag register by then.
    assign ready  = (state_q != adcu_pkg::ST_CALC);
    assign accept = start && ready;

    // One carry chain of nibble slices; the chain is sign-agnostic
    assign nibCarry[0] = cin_q;

    genvar n;
    generate
        for (n = 0; n < DATA_W / NIB; n++) begin : g_nib
            adcu_nibble_add #(
                .W    (NIB)
            ) u_add (
                .a    (opA_q[n*NIB +: NIB]),
                .b    (opB_q[n*NIB +: NIB]),
                .cin  (nibCarry[n]),
                .sum  (sum[n*NIB +: NIB]),
                .cout (nibCarry[n+1])
            );
        end
    endgenerate

    adcu_flag_eval u_flags (
        .opA       (opA_q),
        .opB       (opB_q),
        .sum       (sum),
        .carryHalf (nibCarry[1]),
        .carryOut  (nibCarry[DATA_W/NIB]),
        .flags     (newFlags)
    );

    // Sequencer and operand capture
    always_comb begin
        state_d = state_q;
        opA_d   = opA_q;
        opB_d   = opB_q;
        cin_d   = cin_q;
        dAddr_d = dAddr_q;
        sAddr_d = sAddr_q;
        case (state_q)
            adcu_pkg::ST_IDLE,
            adcu_pkg::ST_COMMIT: begin
                state_d = adcu_pkg::ST_IDLE;
                if (accept) begin
                    state_d = adcu_pkg::ST_CALC;
                    opA_d   = dstVal;
                    opB_d   = srcVal;
                    dAddr_d = dstAddr;
                    sAddr_d = srcAddr;
                    // Carry from the last instruction feeds multi-byte sums
                    cin_d   = flags_q[adcu_pkg::FLG_C];
                end
            end
            adcu_pkg::ST_CALC: begin
                state_d = adcu_pkg::ST_COMMIT;
            end
            default: begin
                state_d = adcu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= adcu_pkg::ST_IDLE;
            opA_q   <= adcu_pkg::DATA_RST;
            opB_q   <= adcu_pkg::DATA_RST;
            cin_q   <= 1'b0;
            dAddr_q <= '0;
            sAddr_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            opA_q   <= opA_d;
            opB_q   <= opB_d;
            cin_q   <= cin_d;
            dAddr_q <= dAddr_d;
            sAddr_q <= sAddr_d;
        end
    end

    // Write-back and flag register
    always_comb begin
        wrEn_d   = 1'b0;
        wrAddr_d = wrAddr_q;
        wrData_d = wrData_q;
        flags_d  = flags_q;
        if (state_q == adcu_pkg::ST_CALC) begin
            wrEn_d   = 1'b1;
            // Only the destination address is ever driven out
            wrAddr_d = dAddr_q;
            wrData_d = sum;
            flags_d  = newFlags;
        end else if (flagLoad) begin
            // Outside loads lose to a commit so flags match the result
            flags_d  = flagIn;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrEn_q   <= 1'b0;
            wrAddr_q <= '0;
            wrData_q <= adcu_pkg::DATA_RST;
            flags_q  <= adcu_pkg::FLAGS_RST;
        end else if (ce) begin
            wrEn_q   <= wrEn_d;
            wrAddr_q <= wrAddr_d;
            wrData_q <= wrData_d;
            flags_q  <= flags_d;
        end
    end

    assign wrEn   = wrEn_q;
    assign wrAddr = wrAddr_q;
    assign wrData = wrData_q;
    assign flags  = flags_q;

    // Reference model for the checks below
    logic [DATA_W:0] refSum;
    logic [NIB:0]    refNib;
    logic            calcStep;

    assign refSum   = {1'b0, opA_q} + {1'b0, opB_q} + {{DATA_W{1'b0}}, cin_q};
    assign refNib   = {1'b0, opA_q[NIB-1:0]} + {1'b0, opB_q[NIB-1:0]} +
                      {{NIB{1'b0}}, cin_q};
    assign calcStep = ce && (state_q == adcu_pkg::ST_CALC);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_sum;
        calcStep |=> wrEn && wrData == $past(refSum[DATA_W-1:0]);
    endproperty
    a_sum: assert property (p_sum)
        else $error("Written sum differs from dst plus src plus carry");

    property p_dst_only;
        ce && accept ##1 ce |=> wrEn && wrAddr == $past(dstAddr, 2);
    endproperty
    a_dst_only: assert property (p_dst_only)
        else $error("Write-back went to other than the destination");

    property p_wr_addr;
        wrEn |-> wrAddr == dAddr_q;
    endproperty
    a_wr_addr: assert property (p_wr_addr)
        else $error("Write address is not the captured destination");

    property p_signed;
        calcStep && opA_q[7] && opB_q[7] |=>
            wrData == $past(opA_q + opB_q + {7'h00, cin_q});
    endproperty
    a_signed: assert property (p_signed)
        else $error("Negative operands not added as two's complement");

    property p_carry;
        calcStep |=> flags[adcu_pkg::FLG_C] == $past(refSum[DATA_W]);
    endproperty
    a_carry: assert property (p_carry)
        else $error("Carry flag does not match carry out of bit seven");

    property p_zero;
        calcStep |=> flags[adcu_pkg::FLG_Z] == (wrData == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("Zero flag does not match the result");

    property p_sign;
        calcStep |=> flags[adcu_pkg::FLG_S] == wrData[7];
    endproperty
    a_sign: assert property (p_sign)
        else $error("Sign flag does not match result bit seven");

    property p_ovf;
        calcStep |=> flags[adcu_pkg::FLG_V] ==
            (($past(opA_q[7]) == $past(opB_q[7])) &&
             (wrData[7] != $past(opA_q[7])));
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("Overflow flag wrong for the operand signs");

    property p_dadj;
        calcStep |=> !flags[adcu_pkg::FLG_D];
    endproperty
    a_dadj: assert property (p_dadj)
        else $error("Decimal-adjust flag not cleared");

    property p_half;
        calcStep |=> flags[adcu_pkg::FLG_H] == $past(refNib[NIB]);
    endproperty
    a_half: assert property (p_half)
        else $error("Half-carry flag does not match low nibble carry");

    property p_cin;
        ce && accept |=> cin_q == $past(flags[adcu_pkg::FLG_C]);
    endproperty
    a_cin: assert property (p_cin)
        else $error("Carry in not taken from the carry flag");

    property p_together;
        ce && !calcStep && !flagLoad |=> $stable(flags) && !$rose(wrEn);
    endproperty
    a_together: assert property (p_together)
        else $error("Flags or write strobe moved outside a commit");

    property p_latency;
        ce && accept ##1 ce |=> wrEn ##1 (!$past(ce) || !wrEn);
    endproperty
    a_latency: assert property (p_latency)
        else $error("Commit not two enabled cycles after start");

    // Enable low must hold the state, strobe, flags, write data and write address
    property p_freeze;
        !ce |=> $stable(state_q) && $stable(flags) && $stable(wrEn) &&
            $stable(wrData) && $stable(wrAddr);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("State moved while the clock enable was low");

    property p_pulse;
        ce && wrEn |=> !wrEn;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("Write-back strobe lasted more than one enabled cycle");

    property p_busy_hold;
        ce && !ready |=> $stable(opA_q) && $stable(opB_q) &&
            $stable(dAddr_q);
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("Start taken while an operation was in flight");

    property p_src_kept;
        wrEn && (sAddr_q != dAddr_q) |-> wrAddr != sAddr_q;
    endproperty
    a_src_kept: assert property (p_src_kept)
        else $error("Write-back aimed at the source location");

endmodule
`default_nettype wire

// ===== tb/adcu_unit_test.sv
// Purpose: Self-checking bench of the add-with-carry unit
// Assumes: Write-back strobe comes within the documented execute latency
// Notes:   The carry is tracked here, not read back; enable dips in one test and in the second reset
`timescale 1ns/100ps
`default_nettype none
module adcu_unit_test;
    logic       mclk;
    logic       rst;
    logic       ce;
    logic       start;
    logic       flagLoad;
    logic [5:0] flagIn;
    logic [7:0] dstVal;
    logic [7:0] srcVal;
    logic [7:0] dstAddr;
    logic [7:0] srcAddr;
    logic       ready;
    logic       wrEn;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [5:0] flags;
    logic       carry;
    int         errors;
    int         cmp_count;

    localparam logic [7:0] EXD [5] = '{8'h10, 8'h10, 8'h20, 8'h20, 8'h20};
    localparam logic [7:0] EXS [5] = '{8'h03, 8'h0a, 8'h03, 8'h0a, 8'h11};
    localparam logic [7:0] EXR [5] = '{8'h14, 8'h1b, 8'h24, 8'h2b, 8'h32};
    // Corner operands: carry out, zero, sign, overflow, half-carry
    localparam logic [16:0] CRN [6] = '{{8'hff, 8'h00, 1'b1},
        {8'h7f, 8'h00, 1'b1}, {8'h80, 8'h80, 1'b0}, {8'h0f, 8'h00, 1'b1},
        {8'h08, 8'h08, 1'b0}, {8'h40, 8'h40, 1'b0}};

    adcu_unit adcu_unit_i (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .start   (start),
        .dstVal  (dstVal),
        .srcVal  (srcVal),
        .dstAddr (dstAddr),
        .srcAddr (srcAddr),
        .flagLoad(flagLoad),
        .flagIn  (flagIn),
        .ready   (ready),
        .wrEn    (wrEn),
        .wrAddr  (wrAddr),
        .wrData  (wrData),
        .flags   (flags)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Result in the low byte, flags C Z S V D H above it
    function automatic logic [13:0] model(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic       c);
        logic [8:0] s;
        logic [4:0] n;
        s = a + b + c;
        n = a[3:0] + b[3:0] + c;
        return {s[8], s[7:0] == 8'h00, s[7], (a[7] == b[7]) &&
                (s[7] != a[7]), 1'b0, n[4], s[7:0]};
    endfunction

    task automatic do_reset(input int cyc);
        rst = 1'b1;
        repeat (cyc) @(posedge mclk);
        #1 rst = 1'b0;
        carry = 1'b0;
        chk({7'h00, wrEn}, 8'h00);
        chk(wrData, 8'h00);
        chk(wrAddr, 8'h00);
        chk({2'b00, flags}, 8'h00);
        chk({7'h00, ready}, 8'h01);
    endtask

    task automatic load_flags(input logic [5:0] f);
        flagLoad = 1'b1;
        flagIn = f;
        @(posedge mclk);
        #1 flagLoad = 1'b0;
        carry = f[5];
        chk({2'b00, flags}, {2'b00, f});
    endtask

    // Returns in the write-back cycle so a next start is back to back
    task automatic run_op(input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] da);
        logic [13:0] e;
        int          n;
        e = model(a, b, carry);
        chk({7'h00, ready}, 8'h01);
        start = 1'b1;
        dstVal = a;
        srcVal = b;
        dstAddr = da;
        srcAddr = ~da;
        @(posedge mclk);
        #1 start = 1'b0;
        n = 0;
        while (wrEn !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1 n++;
        end
        // Strobe is up one edge before the latency edge samples it
        chk(8'(n), 8'(adcu_pkg::EXEC_LAT - 1));
        chk(wrData, e[7:0]);
        chk(wrAddr, da);
        chk({2'b00, flags}, {2'b00, e[13:8]});
        carry = e[13];
    endtask

    task automatic t_examples;
        for (int i = 0; i < 5; i++) begin
            load_flags(6'h20);
            run_op(EXD[i], EXS[i], 8'h01);
            chk(wrData, EXR[i]);
        end
    endtask

    task automatic t_corners;
        for (int i = 0; i < 6; i++) begin
            load_flags({CRN[i][0], 5'h1f});
            run_op(CRN[i][16:9], CRN[i][8:1], 8'h10 + 8'(i));
        end
    endtask

    task automatic t_chain;
        load_flags(6'h00);
        run_op(8'hff, 8'h01, 8'h30);
        run_op(8'h12, 8'h00, 8'h31);
        chk(wrData, 8'h13);
    endtask

    // Start held into the busy cycle and a flag load there are both ignored
    task automatic t_refuse;
        logic [13:0] e;
        e = model(8'h55, 8'h2b, carry);
        start = 1'b1;
        dstVal = 8'h55;
        srcVal = 8'h2b;
        dstAddr = 8'h44;
        srcAddr = 8'h45;
        @(posedge mclk);
        #1 dstVal = 8'hff;
        dstAddr = 8'h77;
        flagLoad = 1'b1;
        flagIn = 6'h3f;
        chk({7'h00, ready}, 8'h00);
        @(posedge mclk);
        #1 start = 1'b0;
        flagLoad = 1'b0;
        chk({7'h00, wrEn}, 8'h01);
        chk(wrData, e[7:0]);
        chk(wrAddr, 8'h44);
        chk({2'b00, flags}, {2'b00, e[13:8]});
        carry = e[13];
        repeat (4) begin
            @(posedge mclk);
            #1 chk({7'h00, wrEn}, 8'h00);
        end
    endtask

    // Enable low holds the op in flight and the strobe once it is up
    task automatic t_freeze;
        logic [13:0] e;
        e = model(8'h3c, 8'h4d, carry);
        start = 1'b1;
        dstVal = 8'h3c;
        srcVal = 8'h4d;
        dstAddr = 8'h52;
        srcAddr = 8'h53;
        @(posedge mclk);
        #1 start = 1'b0;
        ce = 1'b0;
        repeat (3) begin
            @(posedge mclk);
            #1 chk({6'h00, ready, wrEn}, 8'h00);
        end
        ce = 1'b1;
        @(posedge mclk);
        #1 ce = 1'b0;
        flagLoad = 1'b1;
        flagIn = 6'h00;
        chk({7'h00, wrEn}, 8'h01);
        chk(wrData, e[7:0]);
        repeat (2) @(posedge mclk);
        #1 flagLoad = 1'b0;
        chk({1'b0, wrEn, flags}, {2'b01, e[13:8]});
        ce = 1'b1;
        @(posedge mclk);
        #1 chk({7'h00, wrEn}, 8'h00);
        carry = e[13];
    endtask

    task automatic close_out;
        $display("errors %0d cmp_count %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        ce = 1'b1;
        start = 1'b0;
        flagLoad = 1'b0;
        flagIn = 6'h00;
        dstVal = 8'h00;
        srcVal = 8'h00;
        dstAddr = 8'h00;
        srcAddr = 8'h00;
        do_reset(10);
        t_examples();
        t_corners();
        t_chain();
        t_refuse();
        t_freeze();
        // A second reset in mid-run, with the enable low, clears everything
        ce = 1'b0;
        do_reset(2);
        ce = 1'b1;
        run_op(8'h80, 8'h7f, 8'h05);
        close_out();
    end
endmodule
`default_nettype wire
